// ==== common/sfr_pkg.sv ====
package sfr_pkg;

	// ------------------------------------------------------------
	// register select codes on the core-side register port
	// ------------------------------------------------------------
	localparam logic [3:0] REG_AUX_CONTROL = 4'h0;
	localparam logic [3:0] REG_AUX_TRANSCEIVER = 4'h1;
	localparam logic [3:0] REG_CONDITION_FLAGS = 4'h2;
	localparam logic [3:0] REG_CLOCK_WAIT_CONFIG = 4'h3;
	localparam logic [3:0] REG_DATA_STACK_PORT = 4'h4;
	localparam logic [3:0] REG_RX_ERROR_CODES = 4'h5;
	localparam logic [3:0] REG_TX_FILL_PATTERN = 4'h6;
	localparam logic [3:0] REG_IRQ_VECTOR_BASE = 4'h7;
	localparam logic [3:0] REG_IRQ_CONTROL = 4'h8;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ACR_GIE = 0;
	localparam int ACR_LOCKOUT = 1;
	localparam int ACR_COD = 2;
	localparam int ACR_SLOW_READ = 3;
	localparam int ACR_PIN_DIR = 4;
	localparam int CCR_BIDIR_IRQ_PIN = 4;
	localparam int CCR_REMOTE_WR = 5;
	localparam int CCR_REMOTE_RD = 6;
	localparam int CCR_TIMEOUT = 7;
	localparam int DCR_CCS = 7;
	localparam int ICR_MASK_BIDIR = 3;

	// ------------------------------------------------------------
	// reset values and writable-bit masks
	// ------------------------------------------------------------
	localparam logic [7:0] ACR_RESET = 8'h00;
	localparam logic [7:0] ACR_WMASK = 8'hFF;
	localparam logic [7:0] ATR_RESET = 8'h00;
	localparam logic [7:0] DCR_RESET = 8'h9F;
	localparam logic [7:0] FBR_RESET = 8'h00;
	localparam logic [7:0] IBR_RESET = 8'h00;
	localparam logic [7:0] ICR_RESET = 8'hDF;
	localparam logic [7:0] ICR_WMASK = 8'hDF;

	// ------------------------------------------------------------
	// interrupt sources and vector addresses
	// ------------------------------------------------------------
	localparam int NUM_SRC = 5;
	localparam logic [5:0] VEC_NMI = 6'b01_1100;
	localparam logic [5:0] VEC_RX = 6'b00_0100;
	localparam logic [5:0] VEC_TX = 6'b00_1000;
	localparam logic [5:0] VEC_LTA = 6'b00_1100;
	localparam logic [5:0] VEC_BIDIR = 6'b01_0000;
	localparam logic [5:0] VEC_TIMER = 6'b01_0100;
	localparam logic [1:0] RIS_FULL = 2'b00;
	localparam logic [1:0] RIS_AVAIL = 2'b01;
	localparam logic [1:0] RIS_ACTIVE = 2'b11;

	// ------------------------------------------------------------
	// clock selection
	// ------------------------------------------------------------
	localparam logic [1:0] TCS_OSC = 2'b00;
	localparam logic [1:0] TCS_DIV2 = 2'b01;
	localparam logic [1:0] TCS_DIV4 = 2'b10;
	localparam logic [1:0] TCS_EXT = 2'b11;

	// ------------------------------------------------------------
	// timing: t-states per access and line drive hold
	// ------------------------------------------------------------
	localparam logic [3:0] TS_INSTR = 4'h2;
	localparam logic [3:0] TS_DATA = 4'h3;
	localparam logic [3:0] TS_SLOW_READ = 4'h4;
	localparam real HOLD_STEP_US = 0.5;
	localparam real HOLD_REF_MHZ = 8.0;
	// transceiver ticks per hold step at the reference rate
	localparam int HOLD_STEP_TICKS = int'(HOLD_STEP_US * HOLD_REF_MHZ);

	// ------------------------------------------------------------
	// data stack geometry
	// ------------------------------------------------------------
	localparam int STACK_DEPTH = 16;
	localparam int STACK_AW = 4;

endpackage

// ==== rtl/stack_mem.sv ====
`timescale 1ns/1ps
module stack_mem (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [3:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [3:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [16];

	// ------------------------------------------------------------
	// storage with registered read
	// ------------------------------------------------------------
	// no reset on the array: contents are undefined after power-up
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// ==== rtl/cpu_sfr_bank.sv ====
`timescale 1ns/1ps
// Contract
// RULE_01: clock-out disable bit floats the clock output pin; clear drives it.
// RULE_02: remote lockout high refuses every access from the remote system.
// RULE_03: global enable low blocks maskable interrupts; high lets masks decide.
// RULE_04: slow read select makes every data memory read four t-states.
// RULE_05: aux transceiver bits 7-3 set line drive hold; bits 2-0 station address.
// RULE_06: cpu clock select picks oscillator or oscillator divided by two.
// RULE_07: transceiver clock select: osc, osc/2, osc/4, external clock.
// RULE_08: instruction wait field adds zero to three wait states per fetch.
// RULE_09: data wait field adds zero to seven wait states per data access.
// RULE_10: data stack port pushes on write, pops on read, sixteen bytes.
// RULE_11: reserved bits carry no defined value; here they read zero, except aux control bits 7-5, which read back as written.
// RULE_12: vector is base byte, two zeros, six-bit source address.
// RULE_13: priority receiver, transmitter, turnaround, bidirectional, timer.
// RULE_14: receiver source select: full or fault, available or fault, active.
// RULE_15: each mask bit high masks its source; all zero masks none.
// RULE_16: mask bit 3 drives the bidirectional pin while that pin is output.
// RULE_17: pin direction bit: 0 input, 1 output for the bidirectional pin.
// RULE_18: highest-priority unmasked source wins and its vector is fetched.
module cpu_sfr_bank (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic [3:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_WDATA_I,
	output logic [7:0] REG_RDATA_O,
	input wire logic [3:0] ALU_FLAGS_I,
	input wire logic TIMEOUT_I,
	input wire logic [4:0] RX_ERR_CODE_I,
	input wire logic RX_FIFO_FULL_I,
	input wire logic RX_FAULT_I,
	input wire logic RX_WORD_AVAIL_I,
	input wire logic RX_ACTIVE_I,
	input wire logic TX_IRQ_I,
	input wire logic LTA_IRQ_I,
	input wire logic TIMER_IRQ_I,
	input wire logic NMI_I,
	output logic IRQ_REQ_O,
	output logic [15:0] IRQ_VECTOR_O,
	input wire logic BIDIR_IRQ_I,
	output logic BIDIR_IRQ_O,
	output logic BIDIR_IRQ_OE_O,
	input wire logic REMOTE_REQ_I,
	input wire logic REMOTE_RD_DONE_I,
	input wire logic REMOTE_WR_DONE_I,
	output logic REMOTE_GRANT_O,
	output logic REMOTE_REFUSED_O,
	input wire logic EXT_XCVR_CLK_I,
	output logic CPU_TICK_O,
	output logic XCVR_TICK_O,
	output logic CLK_OUT_O,
	output logic CLK_OUT_OE_O,
	input wire logic MEM_START_I,
	input wire logic MEM_DATA_I,
	input wire logic MEM_READ_I,
	output logic MEM_RD_STB_O,
	output logic MEM_DONE_O,
	input wire logic MUX_MODE_I,
	input wire logic FILL_DONE_I,
	output logic LINE_DRIVE_O,
	output logic [2:0] RX_STATION_ADDR_O,
	output logic [7:0] FILL_PATTERN_O
);
	import sfr_pkg::*;

	typedef enum logic [2:0] {
		MS_IDLE = 3'b001,
		MS_ADDR = 3'b010,
		MS_STROBE = 3'b100
	} mem_state_t;

	logic [7:0] acr_q, atr_q, dcr_q, fbr_q, ibr_q, icr_q;
	logic rr_q, rw_q, to_q;
	logic bidir_m_q, bidir_s_q, req_m_q, req_s_q, ext_m_q, ext_s_q, ext_d_q;
	logic [1:0] div_q;
	logic cpu_tick_q, xcvr_tick_q;
	logic wr_acr, wr_atr, wr_ccr, wr_dcr, wr_ds, wr_fbr, wr_ibr, wr_icr, rd_ds;
	logic [3:0] sp_q;
	logic [7:0] stack_top;
	logic [7:0] rdata_d;
	logic rx_cond;
	logic [NUM_SRC-1:0] src, pending;
	logic [5:0] vec_addr;
	logic irq_d;
	mem_state_t ms_q;
	logic [3:0] ts_cnt_q, ts_total, strobe_at;
	logic [7:0] hold_q;
	logic [1:0] step_q;

	// ------------------------------------------------------------
	// write and read decode
	// ------------------------------------------------------------
	assign wr_acr = REG_WR_I && (REG_ADDR_I == REG_AUX_CONTROL);
	assign wr_atr = REG_WR_I && (REG_ADDR_I == REG_AUX_TRANSCEIVER);
	assign wr_ccr = REG_WR_I && (REG_ADDR_I == REG_CONDITION_FLAGS);
	assign wr_dcr = REG_WR_I && (REG_ADDR_I == REG_CLOCK_WAIT_CONFIG);
	assign wr_ds = REG_WR_I && (REG_ADDR_I == REG_DATA_STACK_PORT);
	assign wr_fbr = REG_WR_I && (REG_ADDR_I == REG_TX_FILL_PATTERN);
	assign wr_ibr = REG_WR_I && (REG_ADDR_I == REG_IRQ_VECTOR_BASE);
	assign wr_icr = REG_WR_I && (REG_ADDR_I == REG_IRQ_CONTROL);
	assign rd_ds = REG_RD_I && (REG_ADDR_I == REG_DATA_STACK_PORT);

	// ------------------------------------------------------------
	// plain control registers
	// ------------------------------------------------------------
	// reserved ICR bit 5 is masked off; ACR_WMASK passes all eight aux control bits, so ACR bits 7-5 hold state
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			acr_q <= ACR_RESET;
			atr_q <= ATR_RESET;
			dcr_q <= DCR_RESET;
			fbr_q <= FBR_RESET;
			ibr_q <= IBR_RESET;
			icr_q <= ICR_RESET;
		end else begin
			if (wr_acr) begin
				acr_q <= REG_WDATA_I & ACR_WMASK;
			end
			if (wr_atr) begin
				atr_q <= REG_WDATA_I;
			end
			if (wr_dcr) begin
				dcr_q <= REG_WDATA_I;
			end
			if (wr_fbr) begin
				fbr_q <= REG_WDATA_I;
			end
			if (wr_ibr) begin
				ibr_q <= REG_WDATA_I;
			end
			if (wr_icr) begin
				icr_q <= REG_WDATA_I & ICR_WMASK;
			end
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// pins are asynchronous to this clock, two stages before use
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			bidir_m_q <= 1'b0;
			bidir_s_q <= 1'b0;
			req_m_q <= 1'b0;
			req_s_q <= 1'b0;
			ext_m_q <= 1'b0;
			ext_s_q <= 1'b0;
			ext_d_q <= 1'b0;
		end else begin
			bidir_m_q <= BIDIR_IRQ_I;
			bidir_s_q <= bidir_m_q;
			req_m_q <= REMOTE_REQ_I;
			req_s_q <= req_m_q;
			ext_m_q <= EXT_XCVR_CLK_I;
			ext_s_q <= ext_m_q;
			ext_d_q <= ext_s_q;
		end
	end

	// ------------------------------------------------------------
	// sticky condition flags
	// ------------------------------------------------------------
	// a new event in the clearing cycle keeps the flag set
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rr_q <= 1'b0;
			rw_q <= 1'b0;
			to_q <= 1'b0;
		end else begin
			rr_q <= REMOTE_RD_DONE_I || (rr_q && !(wr_ccr && REG_WDATA_I[CCR_REMOTE_RD]));
			rw_q <= REMOTE_WR_DONE_I || (rw_q && !(wr_ccr && REG_WDATA_I[CCR_REMOTE_WR]));
			to_q <= TIMEOUT_I || (to_q && !(wr_ccr && REG_WDATA_I[CCR_TIMEOUT]));
		end
	end

	// ------------------------------------------------------------
	// remote access gate
	// ------------------------------------------------------------
	// RULE_02: lockout refuses
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			REMOTE_GRANT_O <= 1'b0;
			REMOTE_REFUSED_O <= 1'b0;
		end else begin
			REMOTE_GRANT_O <= req_s_q && !acr_q[ACR_LOCKOUT];
			REMOTE_REFUSED_O <= req_s_q && acr_q[ACR_LOCKOUT];
		end
	end

	// ------------------------------------------------------------
	// clock enables and clock output
	// ------------------------------------------------------------
	// RULE_06: cpu rate select
	// RULE_07: transceiver rate select
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			div_q <= 2'b00;
			cpu_tick_q <= 1'b0;
			xcvr_tick_q <= 1'b0;
		end else begin
			div_q <= div_q + 2'b01;
			cpu_tick_q <= !dcr_q[DCR_CCS] || div_q[0];
			unique case (dcr_q[6:5])
				TCS_OSC: xcvr_tick_q <= 1'b1;
				TCS_DIV2: xcvr_tick_q <= div_q[0];
				TCS_DIV4: xcvr_tick_q <= (div_q == 2'b11);
				TCS_EXT: xcvr_tick_q <= ext_s_q && !ext_d_q;
			endcase
		end
	end
	assign CPU_TICK_O = cpu_tick_q;
	assign XCVR_TICK_O = xcvr_tick_q;

	// clock out toggles per cpu tick, so it runs at half the cpu tick rate
	// RULE_01: disable floats pin
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			CLK_OUT_O <= 1'b0;
			CLK_OUT_OE_O <= 1'b0;
		end else begin
			if (cpu_tick_q) begin
				CLK_OUT_O <= !CLK_OUT_O;
			end
			CLK_OUT_OE_O <= !acr_q[ACR_COD];
		end
	end

	// ------------------------------------------------------------
	// memory access timing
	// ------------------------------------------------------------
	// RULE_04: slow read length
	// RULE_08: instruction waits
	// RULE_09: data waits
	always_comb begin
		if (!MEM_DATA_I) begin
			ts_total = TS_INSTR + {2'b00, dcr_q[4:3]};
			strobe_at = 4'h1;
		end else if (MEM_READ_I && acr_q[ACR_SLOW_READ]) begin
			ts_total = TS_SLOW_READ + {1'b0, dcr_q[2:0]};
			strobe_at = 4'h2;
		end else begin
			ts_total = TS_DATA + {1'b0, dcr_q[2:0]};
			strobe_at = 4'h1;
		end
	end

	// counter runs on cpu ticks; the start request must hold its qualifiers
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ms_q <= MS_IDLE;
			ts_cnt_q <= 4'h0;
			MEM_DONE_O <= 1'b0;
			MEM_RD_STB_O <= 1'b0;
		end else begin
			MEM_DONE_O <= 1'b0;
			unique case (ms_q)
				MS_IDLE: begin
					if (MEM_START_I) begin
						ms_q <= MS_ADDR;
						ts_cnt_q <= 4'h0;
					end
				end
				MS_ADDR: begin
					if (cpu_tick_q) begin
						ts_cnt_q <= ts_cnt_q + 4'h1;
						if (ts_cnt_q + 4'h1 == strobe_at) begin
							ms_q <= MS_STROBE;
							MEM_RD_STB_O <= MEM_READ_I;
						end
					end
				end
				MS_STROBE: begin
					if (cpu_tick_q) begin
						ts_cnt_q <= ts_cnt_q + 4'h1;
						if (ts_cnt_q + 4'h1 == ts_total) begin
							ms_q <= MS_IDLE;
							MEM_DONE_O <= 1'b1;
							MEM_RD_STB_O <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// line drive hold after the last fill bit
	// ------------------------------------------------------------
	// RULE_05: hold in half-microsecond steps
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			hold_q <= 8'h00;
			step_q <= 2'b00;
			LINE_DRIVE_O <= 1'b0;
		end else if (FILL_DONE_I) begin
			hold_q <= MUX_MODE_I ? {3'b000, atr_q[7:3]} : 8'h00;
			step_q <= 2'b00;
			LINE_DRIVE_O <= MUX_MODE_I && (atr_q[7:3] != 5'b00000);
		end else if (xcvr_tick_q && (hold_q != 8'h00)) begin
			step_q <= step_q + 2'b01;
			if (step_q == 2'(HOLD_STEP_TICKS - 1)) begin
				hold_q <= hold_q - 8'h01;
				LINE_DRIVE_O <= (hold_q != 8'h01);
			end
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			RX_STATION_ADDR_O <= 3'b000;
			FILL_PATTERN_O <= 8'h00;
		end else begin
			RX_STATION_ADDR_O <= atr_q[2:0];
			FILL_PATTERN_O <= fbr_q;
		end
	end

	// ------------------------------------------------------------
	// data stack
	// ------------------------------------------------------------
	// RULE_10: push and pop
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sp_q <= 4'h0;
		end else if (wr_ds) begin
			sp_q <= sp_q + 4'h1;
		end else if (rd_ds) begin
			sp_q <= sp_q - 4'h1;
		end
	end

	// top-of-stack is prefetched, so stack accesses need one idle cycle between
	stack_mem stack_mem_inst (
		.clk_i(CLK_I),
		.we_i(wr_ds),
		.waddr_i(sp_q),
		.wdata_i(REG_WDATA_I),
		.raddr_i(sp_q - 4'h1),
		.rdata_o(stack_top)
	);

	// ------------------------------------------------------------
	// interrupt sources, masking and priority
	// ------------------------------------------------------------
	// RULE_14: receiver condition
	always_comb begin
		unique case (icr_q[7:6])
			RIS_FULL: rx_cond = RX_FIFO_FULL_I || RX_FAULT_I;
			RIS_AVAIL: rx_cond = RX_WORD_AVAIL_I || RX_FAULT_I;
			RIS_ACTIVE: rx_cond = RX_ACTIVE_I;
			default: rx_cond = 1'b0;
		endcase
	end

	assign src = {TIMER_IRQ_I, bidir_s_q && !acr_q[ACR_PIN_DIR], LTA_IRQ_I, TX_IRQ_I, rx_cond};
	// RULE_15: per-source mask
	assign pending = src & ~icr_q[4:0];

	// RULE_13: fixed priority
	// RULE_18: winner selects vector
	always_comb begin
		vec_addr = VEC_TIMER;
		if (pending[0]) begin
			vec_addr = VEC_RX;
		end else if (pending[1]) begin
			vec_addr = VEC_TX;
		end else if (pending[2]) begin
			vec_addr = VEC_LTA;
		end else if (pending[3]) begin
			vec_addr = VEC_BIDIR;
		end
		if (NMI_I) begin
			vec_addr = VEC_NMI;
		end
	end

	// RULE_03: global enable
	assign irq_d = NMI_I || (acr_q[ACR_GIE] && (pending != 5'b00000));

	// RULE_12: vector assembly
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			IRQ_REQ_O <= 1'b0;
			IRQ_VECTOR_O <= 16'h0000;
		end else begin
			IRQ_REQ_O <= irq_d;
			IRQ_VECTOR_O <= {ibr_q, 2'b00, vec_addr};
		end
	end

	// ------------------------------------------------------------
	// bidirectional interrupt pin
	// ------------------------------------------------------------
	// RULE_16: mask bit drives pin
	// RULE_17: direction bit
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			BIDIR_IRQ_O <= 1'b0;
			BIDIR_IRQ_OE_O <= 1'b0;
		end else begin
			BIDIR_IRQ_O <= icr_q[ICR_MASK_BIDIR];
			BIDIR_IRQ_OE_O <= acr_q[ACR_PIN_DIR];
		end
	end

	// ------------------------------------------------------------
	// register read
	// ------------------------------------------------------------
	// RULE_11: reserved read zero
	always_comb begin
		unique case (REG_ADDR_I)
			REG_AUX_CONTROL: rdata_d = acr_q;
			REG_AUX_TRANSCEIVER: rdata_d = atr_q;
			REG_CONDITION_FLAGS: rdata_d = {to_q, rr_q, rw_q, bidir_s_q, ALU_FLAGS_I};
			REG_CLOCK_WAIT_CONFIG: rdata_d = dcr_q;
			REG_DATA_STACK_PORT: rdata_d = stack_top;
			REG_RX_ERROR_CODES: rdata_d = {3'b000, RX_ERR_CODE_I};
			REG_TX_FILL_PATTERN: rdata_d = fbr_q;
			REG_IRQ_VECTOR_BASE: rdata_d = ibr_q;
			REG_IRQ_CONTROL: rdata_d = icr_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= rdata_d;
		end
	end
endmodule

// ==== verif/cpu_sfr_bank_monitor.sv ====
`timescale 1ns/1ps
module cpu_sfr_bank_monitor (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic [3:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic RX_FIFO_FULL_I,
	input wire logic RX_FAULT_I,
	input wire logic RX_WORD_AVAIL_I,
	input wire logic RX_ACTIVE_I,
	input wire logic TX_IRQ_I,
	input wire logic LTA_IRQ_I,
	input wire logic TIMER_IRQ_I,
	input wire logic NMI_I,
	input wire logic BIDIR_IRQ_I,
	input wire logic IRQ_REQ_O,
	input wire logic [15:0] IRQ_VECTOR_O,
	input wire logic BIDIR_IRQ_OE_O,
	input wire logic REMOTE_REQ_I,
	input wire logic REMOTE_GRANT_O,
	input wire logic REMOTE_REFUSED_O,
	input wire logic CLK_OUT_OE_O,
	input wire logic MEM_DONE_O,
	input wire logic MEM_RD_STB_O,
	input wire logic MUX_MODE_I,
	input wire logic FILL_DONE_I,
	input wire logic LINE_DRIVE_O
);
	import sfr_pkg::*;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!NRST_I);
	// no source of any kind, bidir pin included
	wire logic quiet = !(RX_FIFO_FULL_I | RX_FAULT_I | RX_WORD_AVAIL_I | RX_ACTIVE_I |
		TX_IRQ_I | LTA_IRQ_I | TIMER_IRQ_I | NMI_I | BIDIR_IRQ_I);
	wire logic wr_acr = REG_WR_I && REG_ADDR_I == REG_AUX_CONTROL;

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	AST_VEC_ZEROS: assert property (IRQ_REQ_O |-> IRQ_VECTOR_O[7:6] == 2'b00)
		else $error("vector bits 7:6 not zero");
	AST_NMI_VEC: assert property (NMI_I |=> IRQ_REQ_O && IRQ_VECTOR_O[5:0] == VEC_NMI)
		else $error("nmi not vectored");
	AST_TX_SRC: assert property (IRQ_REQ_O && IRQ_VECTOR_O[5:0] == VEC_TX |->
		$past(TX_IRQ_I) && !$past(NMI_I)) else $error("tx vector without cause");
	AST_NO_SRC: assert property (quiet [*4] |=> !IRQ_REQ_O)
		else $error("request with no source");
	AST_DONE_PULSE: assert property (MEM_DONE_O |=> !MEM_DONE_O)
		else $error("done longer than one cycle");
	AST_STB_FALL: assert property (MEM_DONE_O |-> !MEM_RD_STB_O)
		else $error("read strobe high at done");
	AST_REMOTE_EXCL: assert property (!(REMOTE_GRANT_O && REMOTE_REFUSED_O))
		else $error("grant and refuse together");
	AST_REMOTE_IDLE: assert property ((!REMOTE_REQ_I) [*5] |->
		!REMOTE_GRANT_O && !REMOTE_REFUSED_O) else $error("remote answer without request");
	AST_BIDIR_OE: assert property (wr_acr ##1 (!REG_WR_I) [*3] |->
		BIDIR_IRQ_OE_O == $past(REG_WDATA_I[ACR_PIN_DIR], 3)) else $error("bidir oe wrong");
	AST_CLKOUT_OE: assert property (wr_acr ##1 (!REG_WR_I) [*3] |->
		CLK_OUT_OE_O == !$past(REG_WDATA_I[ACR_COD], 3)) else $error("clock out oe wrong");
	AST_LINE_START: assert property ($rose(LINE_DRIVE_O) |->
		($past(FILL_DONE_I) || $past(FILL_DONE_I, 2)) && $past(MUX_MODE_I))
		else $error("line drive without fill end");
endmodule

bind cpu_sfr_bank cpu_sfr_bank_monitor cpu_sfr_bank_monitor_inst (.*);

// ==== verif/core_partner.sv ====
`timescale 1ns/1ps
// far-side stand-in: external transceiver clock and the shared request wire
module core_partner (
	input wire logic ext_run_i,
	input wire logic pin_req_i,
	input wire logic dut_drv_i,
	input wire logic dut_oe_i,
	output logic ext_clk_o,
	output logic pin_o
);
	// 80 ns period, odd phase; stands low when not asked for
	initial begin
		ext_clk_o = 1'b0;
		#3.7;
		forever begin
			#40;
			ext_clk_o = ext_run_i ? ~ext_clk_o : 1'b0;
		end
	end
	// wire level
	// device wins while it drives, else far side's request level
	assign pin_o = dut_oe_i ? dut_drv_i : pin_req_i;
endmodule

// ==== verif/test_cpu_sfr_bank.sv ====
`timescale 1ns/1ps
module test_cpu_sfr_bank;
	import sfr_pkg::*;
	// ------------------------------------------------------------
	// pins and bench state
	// ------------------------------------------------------------
	logic CLK_I = 1'b0;
	logic NRST_I = 1'b0;
	logic [3:0] REG_ADDR_I = 4'h0;
	logic [7:0] REG_WDATA_I = 8'h00;
	logic REG_WR_I = 1'b0, REG_RD_I = 1'b0, TIMEOUT_I = 1'b0, MEM_START_I = 1'b0;
	logic MEM_DATA_I = 1'b0, MEM_READ_I = 1'b0, MUX_MODE_I = 1'b0, FILL_DONE_I = 1'b0;
	logic REMOTE_REQ_I = 1'b0, pin_req = 1'b0, ext_run = 1'b0;
	logic RX_FIFO_FULL_I = 1'b0, REMOTE_RD_DONE_I = 1'b0, REMOTE_WR_DONE_I = 1'b0;
	logic [3:0] ALU_FLAGS_I = 4'h0;
	logic [4:0] RX_ERR_CODE_I = 5'h15;
	logic [6:0] src = 7'h00;
	wire logic NMI_I, TIMER_IRQ_I, LTA_IRQ_I, TX_IRQ_I, RX_ACTIVE_I, RX_WORD_AVAIL_I, RX_FAULT_I;
	wire logic EXT_XCVR_CLK_I, BIDIR_IRQ_I;
	logic [7:0] REG_RDATA_O, FILL_PATTERN_O;
	logic [15:0] IRQ_VECTOR_O;
	logic [2:0] RX_STATION_ADDR_O;
	logic IRQ_REQ_O, BIDIR_IRQ_O, BIDIR_IRQ_OE_O, REMOTE_GRANT_O, REMOTE_REFUSED_O;
	logic CPU_TICK_O, XCVR_TICK_O, CLK_OUT_O, CLK_OUT_OE_O, MEM_RD_STB_O, MEM_DONE_O;
	logic LINE_DRIVE_O;
	int n_errors = 0, compares = 0, t, s, c1, c2, c3;
	// stimulus tables
	logic [3:0] ra[7] = '{4'h0, 4'h1, 4'h3, 4'h6, 4'h7, 4'h8, 4'hF};
	logic [7:0] re[7] = '{8'h00, 8'h00, 8'h9F, 8'h00, 8'h00, 8'hDF, 8'h00};
	logic [6:0] pv[5] = '{7'h3C, 7'h38, 7'h30, 7'h20, 7'h7C};
	logic [5:0] pe[5] = '{VEC_RX, VEC_TX, VEC_LTA, VEC_TIMER, VEC_NMI};
	logic [1:0] rv[4] = '{2'b00, 2'b01, 2'b11, 2'b10};
	logic [6:0] rs[4] = '{7'h01, 7'h02, 7'h04, 7'h07};
	logic [7:0] tv[4] = '{8'h80, 8'h00, 8'h20, 8'h40};
	int e1[4] = '{10, 20, 20, 20};
	int e2[4] = '{20, 20, 10, 5};

	assign {NMI_I, TIMER_IRQ_I, LTA_IRQ_I, TX_IRQ_I, RX_ACTIVE_I, RX_WORD_AVAIL_I, RX_FAULT_I} = src;
	always #5 CLK_I = ~CLK_I;

	cpu_sfr_bank cpu_sfr_bank_inst (.*);
	core_partner core_partner_inst (.ext_run_i(ext_run), .pin_req_i(pin_req),
		.dut_drv_i(BIDIR_IRQ_O), .dut_oe_i(BIDIR_IRQ_OE_O), .ext_clk_o(EXT_XCVR_CLK_I),
		.pin_o(BIDIR_IRQ_I));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [15:0] v, input logic [15:0] e);
		compares++;
		if (v !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask
	// one-cycle strobe; the next call always leaves an idle cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge CLK_I);
		REG_ADDR_I <= a;
		REG_WDATA_I <= v;
		REG_WR_I <= 1'b1;
		@(posedge CLK_I);
		REG_WR_I <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
		@(posedge CLK_I);
		REG_ADDR_I <= a;
		REG_RD_I <= 1'b1;
		@(posedge CLK_I);
		REG_RD_I <= 1'b0;
		#1;
		chk(n, REG_RDATA_O, e);
	endtask
	task automatic go(input logic [6:0] v);
		@(posedge CLK_I);
		src <= v;
	endtask
	task automatic irq(input int n, input logic r, input logic [5:0] v);
		wt(n);
		chk("irq_req", IRQ_REQ_O, r);
		if (r)
			chk("irq_vec", IRQ_VECTOR_O, {8'hA5, 2'b00, v});
	endtask
	// t: cycles from start to done, s: cycle the read strobe first shows
	task automatic mem(input logic dt, input logic r);
		@(posedge CLK_I);
		MEM_START_I <= 1'b1;
		MEM_DATA_I <= dt;
		MEM_READ_I <= r;
		@(posedge CLK_I);
		MEM_START_I <= 1'b0;
		t = 0;
		s = 0;
		do begin
			wt(1);
			t++;
			if (s == 0 && MEM_RD_STB_O === 1'b1)
				s = t;
		end while (MEM_DONE_O !== 1'b1 && t < 40);
	endtask
	task automatic cnt(input int n);
		c1 = 0;
		c2 = 0;
		c3 = 0;
		#1;
		repeat (n) begin
			c1 += (CPU_TICK_O === 1'b1);
			c2 += (XCVR_TICK_O === 1'b1);
			c3 += (LINE_DRIVE_O === 1'b1);
			wt(1);
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge CLK_I);
		NRST_I <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(ra[i], re[i], "reset");
		wr(4'h8, 8'hFF);
		rd(4'h8, 8'hDF, "irq_control");
		wr(4'h5, 8'hFF);
		wr(4'hF, 8'hFF);
		rd(4'h5, 8'h15, "err_codes");
		rd(4'hF, 8'h00, "unmapped");
		wr(4'h6, 8'h3C);
		rd(4'h6, 8'h3C, "fill");
		chk("fill_pins", FILL_PATTERN_O, 8'h3C);
		// condition flags: mirrors, event set, write-one clear
		@(posedge CLK_I);
		ALU_FLAGS_I <= 4'hA;
		{TIMEOUT_I, REMOTE_RD_DONE_I, REMOTE_WR_DONE_I} <= 3'b111;
		@(posedge CLK_I);
		{TIMEOUT_I, REMOTE_RD_DONE_I, REMOTE_WR_DONE_I} <= 3'b000;
		rd(4'h2, 8'hEA, "flags");
		wr(4'h2, 8'hA0);
		rd(4'h2, 8'h4A, "flags");
		for (int i = 0; i < 16; i++)
			wr(4'h4, 8'(i * 17 + 3));
		for (int i = 15; i >= 0; i--)
			rd(4'h4, 8'(i * 17 + 3), "stack");
		$display("test registers done");
		// interrupt priority, receiver select, masks, global enable
		wr(4'h7, 8'hA5);
		wr(4'h8, 8'hC0);
		wr(4'h0, 8'h01);
		for (int i = 0; i < 5; i++) begin
			go(pv[i]);
			irq(2, 1'b1, pe[i]);
		end
		for (int i = 0; i < 4; i++) begin
			wr(4'h8, {rv[i], 6'h00});
			go(rs[i]);
			irq(2, i < 3, VEC_RX);
		end
		wr(4'h8, 8'hC2);
		go(7'h08);
		irq(2, 1'b0, VEC_TX);
		wr(4'h8, 8'hC0);
		irq(3, 1'b1, VEC_TX);
		wr(4'h0, 8'h00);
		irq(3, 1'b0, VEC_TX);
		go(7'h48);
		irq(2, 1'b1, VEC_NMI);
		wr(4'h0, 8'h01);
		go(7'h00);
		pin_req <= 1'b1;
		irq(5, 1'b1, VEC_BIDIR);
		wr(4'h8, 8'hC8);
		irq(4, 1'b0, VEC_BIDIR);
		pin_req <= 1'b0;
		wr(4'h0, 8'h11);
		irq(4, 1'b0, VEC_BIDIR);
		chk("bidir_out", {BIDIR_IRQ_OE_O, BIDIR_IRQ_O}, 2'b11);
		wr(4'h8, 8'hC0);
		wt(4);
		chk("bidir_out", {BIDIR_IRQ_OE_O, BIDIR_IRQ_O}, 2'b10);
		$display("test interrupts done");
		wr(4'h0, 8'h04);
		wt(4);
		chk("clk_out_oe", CLK_OUT_OE_O, 1'b0);
		wr(4'h0, 8'h00);
		wt(4);
		chk("clk_out_oe", CLK_OUT_OE_O, 1'b1);
		wr(4'h0, 8'h02);
		REMOTE_REQ_I <= 1'b1;
		wt(6);
		chk("remote", {REMOTE_GRANT_O, REMOTE_REFUSED_O}, 2'b01);
		wr(4'h0, 8'h00);
		wt(6);
		chk("remote", {REMOTE_GRANT_O, REMOTE_REFUSED_O}, 2'b10);
		@(posedge CLK_I) REMOTE_REQ_I <= 1'b0;
		$display("test pins done");
		// access lengths at one tick per cycle
		for (int i = 0; i < 4; i++) begin
			wr(4'h3, {3'b000, 2'(i), 3'b000});
			mem(1'b0, 1'b1);
			chk("instr_len", 16'(t), 16'(2 + i));
		end
		for (int i = 0; i < 8; i++) begin
			wr(4'h3, {5'b00000, 3'(i)});
			mem(1'b1, 1'b0);
			chk("data_len", 16'(t), 16'(3 + i));
		end
		wr(4'h3, 8'h00);
		mem(1'b1, 1'b1);
		chk("read_len", 16'({t[7:0], s[7:0]}), 16'h0301);
		wr(4'h0, 8'h08);
		mem(1'b1, 1'b1);
		chk("slow_len", 16'({t[7:0], s[7:0]}), 16'h0402);
		wr(4'h0, 8'h00);
		$display("test memory done");
		for (int i = 0; i < 4; i++) begin
			wr(4'h3, tv[i]);
			wt(4);
			cnt(20);
			chk("cpu_ticks", 16'(c1), 16'(e1[i]));
			chk("xcvr_ticks", 16'(c2), 16'(e2[i]));
		end
		wr(4'h3, 8'h60);
		ext_run <= 1'b1;
		wt(12);
		s = CLK_OUT_O;
		cnt(161);
		chk("ext_ticks", c2 >= 19 && c2 <= 21, 1'b1);
		chk("clk_out", CLK_OUT_O, !s);
		ext_run <= 1'b0;
		wr(4'h3, 8'h00);
		$display("test clocks done");
		for (int i = 0; i < 3; i++) begin
			wr(4'h1, i == 1 ? 8'h05 : 8'h15);
			MUX_MODE_I <= (i != 2);
			FILL_DONE_I <= 1'b1;
			@(posedge CLK_I);
			FILL_DONE_I <= 1'b0;
			cnt(20);
			chk("line_drive", 16'(c3), i ? 16'h0000 : 16'h0008);
			chk("station", RX_STATION_ADDR_O, 3'h5);
		end
		$display("test line drive done");
		end_of_test();
	end

	// hang guard, far beyond the roughly 700 cycles the tests need
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
endmodule
